/* File: core/adcs_defines.svh */
// Function
// - clearing start bit aborts running conversion
// - abort leaves result register unchanged
// - after abort wait two bit periods, reacquire
// - completion sets flag, clears start, stores result
// - one and a half overhead periods plus one per bit
// - bits after a too-short period are invalid
// - acquisition identical for any kept resolution
// - sleep operation only with RC clock
// - RC clock delays start one instruction cycle
// - sleep completion wakes if interrupt enabled
// - non-RC sleep aborts, powers down, bit stays
// - reset clears control, powers off, aborts
// - power-on reset leaves result uninitialised
// - writing C1 selects RC, powers on, channel 0
// - selects give 2, 8, 32 Tosc or RC
// - full conversion lasts 9.5 bit periods
// - capacitor disconnected 2 periods after completion
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

`define ADCS_OFF_CTRL       2'h0
`define ADCS_OFF_RESULT     2'h1
`define ADCS_OFF_IRQEN      2'h2
`define ADCS_OFF_INVAL      2'h3

`define ADCS_BIT_CLK_HI     7
`define ADCS_BIT_CLK_LO     6
`define ADCS_BIT_CHAN_HI    5
`define ADCS_BIT_CHAN_LO    3
`define ADCS_BIT_START      2
`define ADCS_BIT_FLAG       1
`define ADCS_BIT_PWR        0
`define ADCS_BIT_IE         0
`define ADCS_BIT_GIE        1

`define ADCS_CTRL_RESET     8'h00
`define ADCS_IRQEN_RESET    2'h0
`define ADCS_CLKSEL_RC      2'h3

`define ADCS_TOSC_DIV_00    2
`define ADCS_TOSC_DIV_01    8
`define ADCS_TOSC_DIV_10    32
`define ADCS_HALF_DIV_00    5'h01
`define ADCS_HALF_DIV_01    5'h04
`define ADCS_HALF_DIV_10    5'h10

`define ADCS_CLK_NS         50
`define ADCS_INSTR_NS       200
`define ADCS_INSTR_CYCLES   ((`ADCS_INSTR_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_PERIOD_MIN_NS  1600

`define ADCS_HALVES_OVH     5'h03
`define ADCS_HALVES_FIRST   5'h05
`define ADCS_HALVES_TOTAL   5'h13
`define ADCS_HALVES_HOLD    5'h04

`endif

/* File: core/adcs_pkg.sv */
package adcs_pkg;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_ACQ   = 3'b001,
    ST_DELAY = 3'b010,
    ST_CONV  = 3'b011,
    ST_HOLD  = 3'b100
  } adcs_state_e;

  typedef struct packed {
    adcs_state_e state;
    logic [1:0]  clksel;
    logic [2:0]  chan;
    logic        start;
    logic        flag;
    logic        pwr;
    logic [7:0]  result;
    logic        ie;
    logic        global_irq_enable;
    logic [7:0]  inval;
    logic [7:0]  sar;
    logic [2:0]  bit_idx;
    logic [4:0]  hcnt;
    logic [4:0]  dcnt;
    logic [2:0]  dly;
    logic [7:0]  rdata;
    logic        irq;
    logic        wake;
  } adcs_st_s;

endpackage

/* File: core/adcs_sequencer.sv */
`timescale 1ns/10ps
`include "adcs_defines.svh"

module adcs_sequencer #(
  parameter int PERIOD_MIN_NS = `ADCS_PERIOD_MIN_NS
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       cmp_in,
  input  wire logic       rc_half_tick,
  input  wire logic       sleep_active,
  output logic            adc_enable,
  output logic            sample_connect,
  output logic      [7:0] sar_trial,
  output logic      [2:0] channel_sel,
  output logic            irq_req,
  output logic            wake_req
);

  localparam logic [2:0] INSTR_LAST = 3'(`ADCS_INSTR_CYCLES - 1);

  adcs_pkg::adcs_st_s st_reg;
  adcs_pkg::adcs_st_s st_next;

  logic       wr_ctrl;
  logic       half_tick;
  logic [4:0] half_div;
  logic       sleep_kill;
  logic       abort_sw;
  logic       short_period;
  logic [4:0] hcnt_inc;
  logic [7:0] bit_mask;
  logic       deciding;
  logic       completing;
  logic [7:0] sar_decided;

  ////////////////////////////////////////////////////////////////////////////
  // decode and timing helpers

  assign wr_ctrl  = reg_wr && (reg_addr == `ADCS_OFF_CTRL);
  assign hcnt_inc = st_reg.hcnt + 5'h01;
  assign bit_mask = 8'h01 << st_reg.bit_idx;

  always_comb
  begin
    unique case (st_reg.clksel)
      2'h0:    half_div = `ADCS_HALF_DIV_00;
      2'h1:    half_div = `ADCS_HALF_DIV_01;
      2'h2:    half_div = `ADCS_HALF_DIV_10;
      2'h3:    half_div = `ADCS_HALF_DIV_10;
    endcase
  end

  // rc clock counted as ticks from the oscillator cell, not a second domain
  assign half_tick = (st_reg.clksel == `ADCS_CLKSEL_RC) ? rc_half_tick :
                     (st_reg.dcnt == half_div - 5'h01);

  // rc assumed always long enough; only oscillator selects can be too fast
  always_comb
  begin
    unique case (st_reg.clksel)
      2'h0:    short_period = (`ADCS_TOSC_DIV_00 * `ADCS_CLK_NS) < PERIOD_MIN_NS;
      2'h1:    short_period = (`ADCS_TOSC_DIV_01 * `ADCS_CLK_NS) < PERIOD_MIN_NS;
      2'h2:    short_period = (`ADCS_TOSC_DIV_10 * `ADCS_CLK_NS) < PERIOD_MIN_NS;
      2'h3:    short_period = 1'b0;
    endcase
  end

  assign sleep_kill = sleep_active && (st_reg.clksel != `ADCS_CLKSEL_RC);
  assign abort_sw   = wr_ctrl && !reg_wdata[`ADCS_BIT_START] &&
                      ((st_reg.state == adcs_pkg::ST_CONV) ||
                       (st_reg.state == adcs_pkg::ST_DELAY));

  // a bit is decided at the end of its own full bit period
  assign deciding    = (st_reg.state == adcs_pkg::ST_CONV) && half_tick &&
                       (hcnt_inc >= `ADCS_HALVES_FIRST) && hcnt_inc[0];
  assign completing  = deciding && (st_reg.bit_idx == 3'h0);
  assign sar_decided = cmp_in ? (st_reg.sar | bit_mask) : st_reg.sar;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_next      = st_reg;
    st_next.wake = 1'b0;
    st_next.dcnt = (half_tick || (st_reg.clksel == `ADCS_CLKSEL_RC)) ?
                   5'h00 : st_reg.dcnt + 5'h01;

    if (wr_ctrl)
    begin
      st_next.clksel = reg_wdata[`ADCS_BIT_CLK_HI:`ADCS_BIT_CLK_LO];
      st_next.chan   = reg_wdata[`ADCS_BIT_CHAN_HI:`ADCS_BIT_CHAN_LO];
      st_next.pwr    = reg_wdata[`ADCS_BIT_PWR];
      st_next.flag   = reg_wdata[`ADCS_BIT_FLAG];
      // a start in the same write that powers up is not honoured
      st_next.start  = reg_wdata[`ADCS_BIT_START] && st_reg.pwr;
    end
    if (reg_wr && (reg_addr == `ADCS_OFF_RESULT))
      st_next.result = reg_wdata;
    if (reg_wr && (reg_addr == `ADCS_OFF_IRQEN))
    begin
      st_next.ie  = reg_wdata[`ADCS_BIT_IE];
      st_next.global_irq_enable = reg_wdata[`ADCS_BIT_GIE];
    end

    unique case (st_reg.state)
      adcs_pkg::ST_OFF:
      begin
        if (st_reg.pwr && !sleep_kill)
          st_next.state = adcs_pkg::ST_ACQ;
      end
      adcs_pkg::ST_ACQ:
      begin
        // acquisition has no notion of kept resolution
        if (st_reg.start)
        begin
          st_next.sar     = 8'h00;
          st_next.inval   = 8'h00;
          st_next.bit_idx = 3'h7;
          st_next.hcnt    = 5'h00;
          st_next.dly     = 3'h0;
          st_next.state   = (st_reg.clksel == `ADCS_CLKSEL_RC) ?
                            adcs_pkg::ST_DELAY : adcs_pkg::ST_CONV;
        end
      end
      adcs_pkg::ST_DELAY:
      begin
        st_next.dly = st_reg.dly + 3'h1;
        if (st_reg.dly == INSTR_LAST)
          st_next.state = adcs_pkg::ST_CONV;
      end
      adcs_pkg::ST_CONV:
      begin
        if (half_tick)
          st_next.hcnt = hcnt_inc;
        if (deciding)
        begin
          st_next.sar                  = sar_decided;
          st_next.inval[st_reg.bit_idx] = short_period;
          st_next.bit_idx              = st_reg.bit_idx - 3'h1;
        end
        if (completing)
        begin
          st_next.result = sar_decided;
          st_next.flag   = 1'b1;
          st_next.start  = 1'b0;
          st_next.wake   = sleep_active && st_reg.ie;
          st_next.hcnt   = 5'h00;
          st_next.state  = adcs_pkg::ST_HOLD;
        end
      end
      adcs_pkg::ST_HOLD:
      begin
        // holding capacitor stays off the input for the whole wait
        if (half_tick)
          st_next.hcnt = hcnt_inc;
        if (half_tick && (hcnt_inc == `ADCS_HALVES_HOLD))
          st_next.state = adcs_pkg::ST_ACQ;
      end
      default:
        st_next.state = adcs_pkg::ST_OFF;
    endcase

    // abort keeps result and flag as software left them
    if (abort_sw && !completing)
    begin
      st_next.hcnt  = 5'h00;
      st_next.state = adcs_pkg::ST_HOLD;
    end
    if (sleep_kill || (wr_ctrl && !reg_wdata[`ADCS_BIT_PWR]) || !st_reg.pwr)
    begin
      st_next.start = 1'b0;
      st_next.state = adcs_pkg::ST_OFF;
    end

    st_next.irq = st_next.flag && st_next.ie && st_next.global_irq_enable;

    st_next.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `ADCS_OFF_CTRL:   st_next.rdata = {st_reg.clksel, st_reg.chan, st_reg.start,
                                           st_reg.flag, st_reg.pwr};
        `ADCS_OFF_RESULT: st_next.rdata = st_reg.result;
        `ADCS_OFF_IRQEN:  st_next.rdata = {6'h00, st_reg.global_irq_enable, st_reg.ie};
        `ADCS_OFF_INVAL:  st_next.rdata = st_reg.inval;
      endcase
    end

    if (!nrst)
    begin
      st_next        = '0;
      st_next.state  = adcs_pkg::ST_OFF;
      {st_next.clksel, st_next.chan, st_next.start, st_next.flag, st_next.pwr} =
        `ADCS_CTRL_RESET;
      {st_next.global_irq_enable, st_next.ie} = `ADCS_IRQEN_RESET;
      // result survives every reset and is never initialised
      st_next.result = st_reg.result;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata      = st_reg.rdata;
  assign adc_enable     = (st_reg.state != adcs_pkg::ST_OFF);
  assign sample_connect = (st_reg.state == adcs_pkg::ST_ACQ);
  assign sar_trial      = ((st_reg.state == adcs_pkg::ST_CONV) &&
                           (st_reg.hcnt >= `ADCS_HALVES_OVH)) ?
                          (st_reg.sar | bit_mask) : st_reg.sar;
  assign channel_sel    = st_reg.chan;
  assign irq_req        = st_reg.irq;
  assign wake_req       = st_reg.wake;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_abort;
    abort_sw && !completing && st_reg.pwr && !sleep_kill && reg_wdata[`ADCS_BIT_PWR];
  endsequence

  sequence s_rc_start;
    st_reg.state == adcs_pkg::ST_ACQ && st_reg.start && st_reg.pwr &&
    st_reg.clksel == `ADCS_CLKSEL_RC && !reg_wr;
  endsequence

  a_abort_keeps_result: assert property (s_abort |=> st_reg.state == adcs_pkg::ST_HOLD &&
    st_reg.result == $past(st_reg.result)) else $error("abort changed result");

  a_abort_no_flag: assert property (s_abort |=>
    st_reg.flag == $past(reg_wdata[`ADCS_BIT_FLAG])) else $error("abort set flag");

  a_hold_to_acq: assert property ($rose(st_reg.state == adcs_pkg::ST_HOLD) &&
    st_reg.clksel == 2'h0 && !reg_wr && !sleep_active |->
    (st_reg.state == adcs_pkg::ST_HOLD)[*4] ##1 st_reg.state == adcs_pkg::ST_ACQ)
    else $error("hold wait wrong");

  a_done_effects: assert property (completing && !sleep_kill |=> st_reg.flag &&
    !st_reg.start && st_reg.result == $past(sar_decided)) else $error("done effects");

  a_conv_length: assert property (completing |->
    hcnt_inc == `ADCS_HALVES_TOTAL) else $error("conversion length");

  a_rc_delay: assert property (s_rc_start |=> (st_reg.state == adcs_pkg::ST_DELAY)[*4])
    else $error("rc start delay");

  a_sleep_abort: assert property (sleep_kill && st_reg.state == adcs_pkg::ST_CONV &&
    !reg_wr |=> st_reg.state == adcs_pkg::ST_OFF && st_reg.pwr && !adc_enable)
    else $error("sleep abort");

  a_sleep_rc_run: assert property (sleep_active && st_reg.clksel == `ADCS_CLKSEL_RC &&
    st_reg.state == adcs_pkg::ST_CONV && st_reg.pwr && !reg_wr |=>
    st_reg.state != adcs_pkg::ST_OFF) else $error("rc sleep stopped");

  a_sleep_wake: assert property (completing && sleep_active && st_reg.ie |=>
    wake_req && st_reg.pwr) else $error("no wake");

  a_irq_request: assert property ($rose(st_reg.flag) && st_reg.ie && st_reg.global_irq_enable |->
    irq_req) else $error("irq missing");

  a_invalid_mark: assert property (deciding && short_period && !sleep_kill && !abort_sw |=>
    st_reg.inval[$past(st_reg.bit_idx)]) else $error("invalid bit");

  a_c1_write: assert property (wr_ctrl && reg_wdata == 8'hC1 |=> st_reg.clksel == 2'h3 &&
    st_reg.pwr && st_reg.chan == 3'h0) else $error("C1 write");

  a_reset_off: assert property (@(posedge clk_sys) disable iff (1'b0) !nrst |=>
    st_reg.state == adcs_pkg::ST_OFF && !st_reg.pwr && !st_reg.start)
    else $error("reset state");

endmodule // adcs_sequencer

/* File: dv/tb_top.sv */
`timescale 1ns/10ps

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end

module tb_top;
  logic       clk_sys;
  logic       nrst;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       cmp_in = 1'b0;
  logic       rc_half_tick = 1'b0;
  logic       sleep_active;
  logic       adc_enable;
  logic       sample_connect;
  logic [7:0] sar_trial;
  logic [2:0] channel_sel;
  logic       irq_req;
  logic       wake_req;
  logic [7:0] target;
  logic [7:0] last_res;
  logic [3:0] rc_cnt = 4'h0;
  int         fails;
  int         tests_run;
  int         cyc = 0;

  adcs_sequencer adcs_sequencer_i (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_in(cmp_in), .rc_half_tick(rc_half_tick), .sleep_active(sleep_active),
    .adc_enable(adc_enable), .sample_connect(sample_connect), .sar_trial(sar_trial),
    .channel_sel(channel_sel), .irq_req(irq_req), .wake_req(wake_req));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // comparator and rc clock stand-ins; registered, yet all dividers, 2 included, give exact codes
  always @(posedge clk_sys)
  begin
    cmp_in <= (sar_trial <= target);
    rc_cnt <= (rc_cnt == 4'h9) ? 4'h0 : rc_cnt + 4'h1;
    rc_half_tick <= (rc_cnt == 4'h9);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic start_conv(input logic [1:0] cs, input logic [7:0] tg);
    target <= tg;
    wr(2'h0, {cs, 6'h01});
    repeat (4) @(posedge clk_sys);
    wr(2'h0, {cs, 6'h05});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    rd(2'h0, d);
    `CHK("ctrl_rst", 8'h00, d)
    rd(2'h2, d);
    `CHK("irqen_rst", 8'h00, d)
    `CHK("enable_rst", 1'b0, adc_enable)
    wr(2'h0, 8'hC1);
    repeat (2) @(posedge clk_sys);
    rd(2'h0, d);
    `CHK("ctrl_c1", 8'hC1, d)
    `CHK("chan0", 3'h0, channel_sel)
    `CHK("acq_on", 1'b1, sample_connect)
  endtask

  // every oscillator divisor: duration, completion, hold gap, invalid-bit mask
  task automatic t_timing();
    logic [7:0] d;
    int div;
    int n;
    int m;
    wr(2'h2, 8'h03);
    for (int cs = 0; cs < 3; cs++)
    begin
      div = (cs == 0) ? 2 / 2 : (cs == 1) ? 8 / 2 : 32 / 2;
      start_conv(cs[1:0], 8'hA5 - cs[7:0]);
      n = 0;
      m = 0;
      #1;
      while (irq_req !== 1'b1 && n < 400)
      begin
        n++;
        @(posedge clk_sys);
        #1;
      end
      n++;
      `CHK("dur_ok", 1'b1, n <= 19 * div + 2 && n >= 18 * div + 3)
      while (sample_connect !== 1'b1 && m < 100)
      begin
        m++;
        @(posedge clk_sys);
        #1;
      end
      `CHK("hold_ok", 1'b1, m >= 3 * div && m <= 4 * div + 1)
      `CHK("irq_on", 1'b1, irq_req)
      rd(2'h0, d);
      `CHK("ctrl_done", {cs[1:0], 6'h03}, d)
      rd(2'h3, d);
      `CHK("inval", (cs == 2) ? 8'h00 : 8'hFF, d)
      rd(2'h1, d);
      if (cs != 0)
        `CHK("result", 8'hA5 - cs[7:0], d)
      last_res = d;
    end
  endtask

  task automatic t_abort();
    logic [7:0] d;
    int m;
    start_conv(2'h1, 8'h3C);
    repeat (30) @(posedge clk_sys);
    wr(2'h0, 8'h41);
    m = 0;
    #1;
    while (sample_connect !== 1'b1 && m < 100)
    begin
      m++;
      @(posedge clk_sys);
      #1;
    end
    `CHK("reacq_ok", 1'b1, m >= 12 && m <= 18)
    rd(2'h0, d);
    `CHK("ctrl_abort", 8'h41, d)
    rd(2'h1, d);
    `CHK("res_kept", last_res, d)
  endtask

  task automatic t_sleep_rc();
    logic [7:0] d;
    int n;
    logic woke;
    wr(2'h2, 8'h01);
    wr(2'h0, 8'hC1);
    repeat (4) @(posedge clk_sys);
    target <= 8'h5A;
    wr(2'h0, 8'hC5);
    sleep_active <= 1'b1;
    woke = 1'b0;
    for (n = 0; n < 400 && !woke; n++)
    begin
      @(posedge clk_sys);
      #1;
      woke = (wake_req === 1'b1);
      if (irq_req !== 1'b0)
        `CHK("irq_no_gie", 1'b0, irq_req)
    end
    `CHK("woke", 1'b1, woke)
    sleep_active <= 1'b0;
    rd(2'h1, d);
    `CHK("rc_result", 8'h5A, d)
    last_res = d;
    rd(2'h0, d);
    `CHK("ctrl_rc", 8'hC3, d)
  endtask

  task automatic t_sleep_osc();
    logic [7:0] d;
    start_conv(2'h1, 8'h11);
    repeat (10) @(posedge clk_sys);
    sleep_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("osc_sleep_off", 1'b0, adc_enable)
    rd(2'h0, d);
    `CHK("pwr_kept", 8'h41, d)
    sleep_active <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("wake_on", 1'b1, adc_enable)
    rd(2'h1, d);
    `CHK("res_sleep", last_res, d)
  endtask

  task automatic t_reset_mid();
    logic [7:0] d;
    start_conv(2'h1, 8'h77);
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
    `CHK("rst_off", 1'b0, adc_enable)
    rd(2'h0, d);
    `CHK("rst_ctrl", 8'h00, d)
    rd(2'h1, d);
    `CHK("rst_res", last_res, d)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_active = 1'b0;
    target = 8'h00;
    last_res = 8'h00;
    fails = 0;
    tests_run = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_timing();
    t_abort();
    t_sleep_rc();
    t_sleep_osc();
    t_reset_mid();
    complete_run();
  end
endmodule // tb_top
